// >>> dv/cma_memory_addressing_tb_top.sv
`timescale 1ns/1ps

module cma_memory_addressing_tb_top;
  import cma_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_req = 1'b0;
  cma_op_t i_op = CMA_OP_NOP;
  logic [6:0] i_addr = 7'h00;
  logic i_sel = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [14:0] i_target = 15'h0000;
  logic i_pc_inc = 1'b0;
  logic i_flags_we = 1'b0;
  logic [2:0] i_flags = 3'b000;
  logic [3:0] ev = 4'h0;
  logic i_stack_reset_en = 1'b0;
  logic [13:0] pm_data;
  logic [14:0] o_pc, o_pm_addr;
  logic [7:0] o_rdata, o_w, o_status, o_irq_control;
  logic [4:0] o_bank, o_depth;
  logic o_busy, o_rvalid, o_pm_rd, o_pm_hef, o_soft_reset;
  logic o_stack_over_flag, o_stack_under_flag;
  int fails = 0;
  int n_compared = 0;

  always #5 i_clk = ~i_clk;

  cma_memory_addressing #(.PM_WORDS(8192), .RAM_BANKS(4))
  i_cma_memory_addressing (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(i_req),
    .i_op(i_op), .i_addr(i_addr), .i_sel(i_sel), .i_wdata(i_wdata),
    .i_target(i_target), .i_pc_inc(i_pc_inc), .i_flags_we(i_flags_we),
    .i_flags(i_flags), .i_wdt_expire(ev[0]), .i_sleep_enter(ev[1]),
    .i_wdt_clear(ev[2]), .i_stack_reset_en(i_stack_reset_en),
    .i_stack_flags_clr(ev[3]), .i_pm_data(pm_data), .o_pc(o_pc),
    .o_busy(o_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr), .o_pm_hef(o_pm_hef),
    .o_w(o_w), .o_status(o_status), .o_bank(o_bank),
    .o_irq_control(o_irq_control), .o_depth(o_depth),
    .o_stack_over_flag(o_stack_over_flag),
    .o_stack_under_flag(o_stack_under_flag), .o_soft_reset(o_soft_reset)
  );

  cma_pm_model i_cma_pm_model (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_pm_rd(o_pm_rd),
    .i_pm_addr(o_pm_addr), .o_pm_data(pm_data)
  );

  task automatic results();
    $display("fails %0d n_compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Returns one settle step after the edge that took the request.
  task automatic op(input cma_op_t o, input logic s, input logic [7:0] d,
                    input logic [14:0] t);
    @(posedge i_clk);
    i_req <= 1'b1;
    i_op <= o;
    i_sel <= s;
    i_wdata <= d;
    i_target <= t;
    @(posedge i_clk);
    i_req <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_addr <= a;
    op(CMA_OP_WRITE, 1'b0, d, 15'h0000);
  endtask

  task automatic rd(input logic [6:0] a);
    i_addr <= a;
    op(CMA_OP_READ, 1'b0, 8'h00, 15'h0000);
  endtask

  task automatic setp(input logic s, input logic [15:0] v);
    wr(s ? 7'h06 : 7'h04, v[7:0]);
    wr(s ? 7'h07 : 7'h05, v[15:8]);
  endtask

  task automatic pulse(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev <= 4'h0;
    #1;
  endtask

  task automatic t_banks();
    wr(7'h20, 8'h11);
    wr(7'h08, 8'h01);
    check("bank", o_bank, 16'h0001);
    wr(7'h20, 8'h77);
    wr(7'h70, 8'h99);
    wr(7'h09, 8'h3C);
    wr(7'h08, 8'h00);
    rd(7'h20);
    check("rvalid", o_rvalid, 16'h0001);
    check("gpr", o_rdata, 16'h0011);
    rd(7'h70);
    check("common", o_rdata, 16'h0099);
    rd(7'h09);
    check("w_any_bank", o_rdata, 16'h003C);
    check("w", o_w, 16'h003C);
    rd(7'h0C);
    check("special", o_rdata, 16'h0000);
    wr(7'h08, 8'h04);
    wr(7'h20, 8'h55);
    rd(7'h20);
    check("unbuilt", o_rdata, 16'h0000);
    wr(7'h08, 8'h00);
  endtask

  task automatic t_indirect();
    setp(1'b0, 16'h2050);
    op(CMA_OP_IND_READ, 1'b0, 8'h00, 15'h0000);
    check("linear", o_rdata, 16'h0077);
    rd(7'h00);
    check("port0", o_rdata, 16'h0077);
    rd(7'h05);
    check("ptr_high", o_rdata, 16'h0020);
    setp(1'b1, 16'h00A1);
    op(CMA_OP_IND_WRITE, 1'b1, 8'h42, 15'h0000);
    wr(7'h08, 8'h01);
    rd(7'h21);
    check("banked_ptr", o_rdata, 16'h0042);
    wr(7'h08, 8'h00);
  endtask

  task automatic pm(input cma_op_t o, input logic [14:0] a, input logic h);
    op(o, 1'b1, 8'h00, 15'h0000);
    check("busy", o_busy, 16'h0001);
    check("pm_rd", o_pm_rd, 16'h0001);
    check("pm_addr", o_pm_addr, a);
    check("pm_hef", o_pm_hef, h);
    @(posedge i_clk);
    #1;
    check("rvalid", o_rvalid, 16'h0001);
    check("pm_byte", o_rdata, a[7:0] ^ 8'h5A);
    check("idle", o_busy, 16'h0000);
  endtask

  task automatic t_program();
    setp(1'b1, 16'h9F80);
    pm(CMA_OP_IND_READ, 15'h1F80, 1'b1);
    setp(1'b1, 16'hA005);
    pm(CMA_OP_IND_TO_W, 15'h0005, 1'b0);
    check("movi_w", o_w, 16'h005F);
    op(CMA_OP_IND_WRITE, 1'b1, 8'hEE, 15'h0000);
    check("no_pm_rd", o_pm_rd, 16'h0000);
    check("no_busy", o_busy, 16'h0000);
  endtask

  task automatic t_stack();
    op(CMA_OP_GOTO, 1'b0, 8'h00, 15'h7FFF);
    check("pc_top", o_pc, 16'h1FFF);
    op(CMA_OP_GOTO, 1'b0, 8'h00, 15'h0010);
    @(posedge i_clk);
    i_pc_inc <= 1'b1;
    @(posedge i_clk);
    i_ce <= 1'b0;
    @(posedge i_clk);
    i_pc_inc <= 1'b0;
    i_ce <= 1'b1;
    #1;
    check("pc_inc", o_pc, 16'h0011);
    op(CMA_OP_CALL, 1'b0, 8'h00, 15'h0456);
    check("call_pc", o_pc, 16'h0456);
    check("depth", o_depth, 16'h0001);
    op(CMA_OP_RETURN, 1'b0, 8'h00, 15'h0000);
    check("ret_pc", o_pc, 16'h0011);
    op(CMA_OP_RETURN, 1'b0, 8'h00, 15'h0000);
    check("under", o_stack_under_flag, 16'h0001);
    check("under_pc", o_pc, 16'h0011);
    pulse(3);
    check("under_clr", o_stack_under_flag, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      op(CMA_OP_CALL, 1'b0, 8'h00, 15'h0100 + 15'(k));
    end
    check("full", o_depth, 16'h0010);
    check("no_over", o_stack_over_flag, 16'h0000);
    op(CMA_OP_CALL, 1'b0, 8'h00, 15'h0200);
    check("over", o_stack_over_flag, 16'h0001);
    check("no_soft", o_soft_reset, 16'h0000);
    i_stack_reset_en <= 1'b1;
    op(CMA_OP_CALL, 1'b0, 8'h00, 15'h0300);
    check("soft", o_soft_reset, 16'h0001);
    i_stack_reset_en <= 1'b0;
    @(posedge i_clk);
    #1;
    check("soft_pc", o_pc, 16'h0000);
    check("soft_depth", o_depth, 16'h0000);
    check("over_kept", o_stack_over_flag, 16'h0001);
  endtask

  task automatic t_irq();
    wr(7'h0B, 8'h80);
    wr(7'h09, 8'h3C);
    op(CMA_OP_IRQ, 1'b0, 8'h00, 15'h0000);
    check("vector", o_pc, 16'h0004);
    check("gie_off", o_irq_control[7], 16'h0000);
    wr(7'h09, 8'h00);
    op(CMA_OP_RETFIE, 1'b0, 8'h00, 15'h0000);
    check("w_back", o_w, 16'h003C);
    check("gie_on", o_irq_control[7], 16'h0001);
  endtask

  task automatic t_status();
    i_flags_we <= 1'b1;
    i_flags <= 3'b101;
    wr(7'h03, 8'hFF);
    i_flags_we <= 1'b0;
    check("alu_wins", o_status, 16'h001D);
    wr(7'h03, 8'h02);
    check("wdt_bits_ro", o_status, 16'h001A);
    pulse(0);
    check("expire", o_status, 16'h000A);
    pulse(1);
    check("sleep", o_status, 16'h0012);
    pulse(2);
    check("clear", o_status, 16'h001A);
  endtask

  initial begin
    #100000;
    fails++;
    results();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    check("pc_rst", o_pc, 16'h0000);
    check("status_rst", o_status, 16'h0018);
    check("depth_rst", o_depth, 16'h0000);
    t_banks();
    t_indirect();
    t_program();
    t_status();
    t_irq();
    t_stack();
    results();
  end
endmodule // cma_memory_addressing_tb_top

// >>> dv/cma_pm_model.sv
`timescale 1ns/1ps

module cma_pm_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_pm_rd,
  input wire logic [14:0] i_pm_addr,
  output logic [13:0] o_pm_data
);
  logic [13:0] junk_reg;

  // Outside a read the lines churn, so a stale word can never pass as data.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      junk_reg <= 14'h1555;
    end else begin
      junk_reg <= ~junk_reg ^ 14'h0F0F;
    end
  end

  // The array is read only; no write path reaches it.
  assign o_pm_data = i_pm_rd ? {i_pm_addr[13:8], i_pm_addr[7:0] ^ 8'h5A}
                             : junk_reg;
endmodule // cma_pm_model

// >>> logic/cma_defines.svh
// Function
// - Return stack: fifteen bits wide, sixteen entries
// - Stack overflow/underflow flags; optional software reset
// - Two sixteen-bit pointers cover data and program
// - Program-space pointer read costs one extra cycle
// - General RAM also mapped into linear range
// - Fifteen-bit program counter, words fourteen bits wide
// - Program addresses wrap inside implemented memory
// - Reset starts at 0000h; interrupt vectors 0004h
// - Top 128 words are high-endurance, low byte
// - Pointer high bit seven selects program memory
// - Move-indirect-to-W takes program word low byte
// - Indirect writes never change program memory
// - Data memory: 32 banks of 128 bytes
// - Bank: core, special, general, common RAM regions
// - Direct accesses use bank select register
// - Unimplemented data locations read as zero
// - Twelve-bit data address: bank then offset
// - Offsets 00h-0Bh hold core registers in order
// - Interrupt entry shadows core registers; return restores
// - All data reachable directly or through pointers
// - Instruction set of exactly 49 instructions
// - ALU flag update blocks status write; timeout bits fixed
`ifndef CMA_DEFINES_SVH
`define CMA_DEFINES_SVH

`define CMA_OFF_PORT0 7'h00
`define CMA_OFF_PORT1 7'h01
`define CMA_OFF_PC_LOW 7'h02
`define CMA_OFF_STATUS 7'h03
`define CMA_OFF_PTR0_LO 7'h04
`define CMA_OFF_PTR0_HI 7'h05
`define CMA_OFF_PTR1_LO 7'h06
`define CMA_OFF_PTR1_HI 7'h07
`define CMA_OFF_BANK 7'h08
`define CMA_OFF_W 7'h09
`define CMA_OFF_PC_HIGH 7'h0A
`define CMA_OFF_IRQ_CTL 7'h0B
`define CMA_CORE_END 7'h0C
`define CMA_RAM_START 7'h20
`define CMA_RAM_SIZE 7'h50
`define CMA_COMMON_START 7'h70
`define CMA_LINEAR_BASE 16'h2000
`define CMA_LINEAR_SIZE 16'h0A00
`define CMA_PM_SEL_BIT 15
`define CMA_STACK_DEPTH 16
`define CMA_STACK_FULL 5'h10
`define CMA_RESET_VEC 15'h0000
`define CMA_IRQ_VEC 15'h0004
`define CMA_HEF_WORDS 15'h0080
`define CMA_STATUS_RST 5'h18
`define CMA_ST_WDT 4
`define CMA_ST_SLEEP 3
`define CMA_GIE_BIT 7

`endif

// >>> logic/cma_memory_addressing.sv
`timescale 1ns/1ps
`include "cma_defines.svh"

module cma_memory_addressing #(
  parameter int PM_WORDS = 8192,
  parameter int RAM_BANKS = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_req,
  input wire cma_pkg::cma_op_t i_op,
  input wire logic [6:0] i_addr,
  input wire logic i_sel,
  input wire logic [7:0] i_wdata,
  input wire logic [14:0] i_target,
  input wire logic i_pc_inc,
  input wire logic i_flags_we,
  input wire logic [2:0] i_flags,
  input wire logic i_wdt_expire,
  input wire logic i_sleep_enter,
  input wire logic i_wdt_clear,
  input wire logic i_stack_reset_en,
  input wire logic i_stack_flags_clr,
  input wire logic [13:0] i_pm_data,
  output logic [14:0] o_pc,
  output logic o_busy,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_pm_rd,
  output logic [14:0] o_pm_addr,
  output logic o_pm_hef,
  output logic [7:0] o_w,
  output logic [7:0] o_status,
  output logic [4:0] o_bank,
  output logic [7:0] o_irq_control,
  output logic [4:0] o_depth,
  output logic o_stack_over_flag,
  output logic o_stack_under_flag,
  output logic o_soft_reset
);
  import cma_pkg::*;

  localparam int RAM_BYTES = RAM_BANKS * int'(`CMA_RAM_SIZE);
  localparam logic [14:0] PM_MASK = 15'(PM_WORDS - 1);
  localparam logic [14:0] HEF_BASE = 15'(PM_WORDS) - `CMA_HEF_WORDS;

  typedef struct packed {
    cma_phase_t phase;
    logic [14:0] pc;
    logic [7:0] pc_hi;
    logic [4:0] status;
    logic [1:0][15:0] ptr;
    logic [4:0] bank_sel;
    logic [7:0] w;
    logic [7:0] irq_ctl;
    logic [`CMA_STACK_DEPTH-1:0][14:0] stack;
    logic [4:0] depth;
    logic [7:0] sh_w;
    logic [2:0] sh_flags;
    logic [4:0] sh_bank;
    logic [7:0] sh_pc_hi;
    logic [1:0][15:0] sh_ptr;
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [15:0][7:0] common;
    logic [7:0] rdata;
    logic rvalid;
    logic pm_rd;
    logic [14:0] pm_addr;
    logic pm_to_w;
    logic hef;
    logic ovf;
    logic unf;
    logic soft_rst;
  } cma_state_t;

  localparam cma_state_t RST_STATE = '{
    phase: CMA_IDLE,
    pc: `CMA_RESET_VEC,
    status: `CMA_STATUS_RST,
    default: '0
  };

  cma_state_t r;
  cma_state_t n;

  // Pointer to {implemented, 12-bit banked address}; program space is
  // handled by the caller from the select bit.
  function automatic logic [12:0] ptr_map(input logic [15:0] p);
    logic [15:0] lin;
    logic [15:0] bank;
    logic [15:0] off;
    lin = p - `CMA_LINEAR_BASE;
    bank = lin / 16'(`CMA_RAM_SIZE);
    off = (lin % 16'(`CMA_RAM_SIZE)) + 16'(`CMA_RAM_START);
    ptr_map = '0;
    if (p[15:12] == 4'h0) begin
      ptr_map = {1'b1, p[11:0]};
    end else if (p >= `CMA_LINEAR_BASE && lin < `CMA_LINEAR_SIZE) begin
      ptr_map = {1'b1, bank[4:0], off[6:0]};
    end
  endfunction

  // General RAM slot of a banked address as {hit, index}.
  function automatic logic [16:0] ram_idx(input logic [11:0] a);
    int idx;
    idx = int'(a[11:7]) * int'(`CMA_RAM_SIZE) + int'(a[6:0])
      - int'(`CMA_RAM_START);
    ram_idx = '0;
    if (a[6:0] >= `CMA_RAM_START && a[6:0] < `CMA_COMMON_START
        && int'(a[11:7]) < RAM_BANKS) begin
      ram_idx = {1'b1, 16'(idx)};
    end
  endfunction

  // Byte seen at a banked address; anything not built reads zero.
  function automatic logic [7:0] rd_byte(input cma_state_t s,
                                         input logic [11:0] a);
    logic [16:0] gi;
    gi = ram_idx(a);
    rd_byte = 8'h00;
    if (a[6:0] < `CMA_CORE_END) begin
      case (a[6:0])
        `CMA_OFF_PC_LOW: rd_byte = s.pc[7:0];
        `CMA_OFF_STATUS: rd_byte = {3'h0, s.status};
        `CMA_OFF_PTR0_LO: rd_byte = s.ptr[0][7:0];
        `CMA_OFF_PTR0_HI: rd_byte = s.ptr[0][15:8];
        `CMA_OFF_PTR1_LO: rd_byte = s.ptr[1][7:0];
        `CMA_OFF_PTR1_HI: rd_byte = s.ptr[1][15:8];
        `CMA_OFF_BANK: rd_byte = {3'h0, s.bank_sel};
        `CMA_OFF_W: rd_byte = s.w;
        `CMA_OFF_PC_HIGH: rd_byte = s.pc_hi;
        `CMA_OFF_IRQ_CTL: rd_byte = s.irq_ctl;
        default: rd_byte = 8'h00;
      endcase
    end else if (gi[16]) begin
      rd_byte = s.ram[gi[15:0]];
    end else if (a[6:0] >= `CMA_COMMON_START) begin
      rd_byte = s.common[a[3:0]];
    end
  endfunction

  always_comb begin
    logic [12:0] map;
    logic [16:0] gi;
    logic [11:0] a;
    logic [15:0] p;
    logic [7:0] rb;
    logic sel;
    logic ind;
    logic rd;
    logic wr;
    logic push;
    logic pop;
    logic srst;
    map = '0;
    gi = '0;
    a = '0;
    p = '0;
    rb = '0;
    sel = 1'b0;
    ind = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    srst = 1'b0;
    n = r;
    if (i_ce) begin
      n.rvalid = 1'b0;
      n.pm_rd = 1'b0;
      n.soft_rst = 1'b0;
      if (i_stack_flags_clr) begin
        n.ovf = 1'b0;
        n.unf = 1'b0;
      end
      if (r.phase == CMA_PM_WAIT) begin
        // Extra cycle: the program word arrives now.
        n.rdata = i_pm_data[7:0];
        if (r.pm_to_w) begin
          n.w = i_pm_data[7:0];
        end
        n.rvalid = 1'b1;
        n.phase = CMA_IDLE;
      end else begin
        if (i_pc_inc) begin
          n.pc = (r.pc + 15'h0001) & PM_MASK;
        end
        if (i_req) begin
          case (i_op)
            CMA_OP_READ, CMA_OP_WRITE: begin
              a = {r.bank_sel, i_addr};
              rd = (i_op == CMA_OP_READ);
              wr = (i_op == CMA_OP_WRITE);
              if (i_addr == `CMA_OFF_PORT0 || i_addr == `CMA_OFF_PORT1) begin
                ind = 1'b1;
                sel = i_addr[0];
              end
            end
            CMA_OP_IND_READ, CMA_OP_IND_TO_W: begin
              ind = 1'b1;
              rd = 1'b1;
              sel = i_sel;
            end
            CMA_OP_IND_WRITE: begin
              ind = 1'b1;
              wr = 1'b1;
              sel = i_sel;
            end
            CMA_OP_CALL, CMA_OP_IRQ: push = 1'b1;
            CMA_OP_RETURN, CMA_OP_RETFIE: pop = 1'b1;
            CMA_OP_GOTO: n.pc = i_target & PM_MASK;
            default: ;
          endcase
        end
        if (ind) begin
          p = r.ptr[sel];
          if (p[`CMA_PM_SEL_BIT]) begin
            // Writes aimed at program space are dropped here.
            if (rd) begin
              n.phase = CMA_PM_WAIT;
              n.pm_rd = 1'b1;
              n.pm_addr = p[14:0] & PM_MASK;
              n.pm_to_w = (i_op == CMA_OP_IND_TO_W);
              n.hef = (p[14:0] & PM_MASK) >= HEF_BASE;
            end
            rd = 1'b0;
            wr = 1'b0;
          end else begin
            map = ptr_map(p);
            a = map[11:0];
            // Ports reached through a pointer read zero and ignore writes.
            if (!map[12] || a[6:0] < `CMA_OFF_PC_LOW) begin
              a = {5'h00, `CMA_OFF_PORT0};
              wr = 1'b0;
            end
          end
        end
        if (rd) begin
          rb = rd_byte(r, a);
          n.rdata = rb;
          n.rvalid = 1'b1;
          if (i_op == CMA_OP_IND_TO_W) begin
            n.w = rb;
          end
        end
        if (wr) begin
          gi = ram_idx(a);
          if (a[6:0] < `CMA_CORE_END) begin
            case (a[6:0])
              `CMA_OFF_PC_LOW: n.pc = {r.pc_hi[6:0], i_wdata} & PM_MASK;
              `CMA_OFF_STATUS: begin
                if (!i_flags_we) begin
                  n.status[2:0] = i_wdata[2:0];
                end
              end
              `CMA_OFF_PTR0_LO: n.ptr[0][7:0] = i_wdata;
              `CMA_OFF_PTR0_HI: n.ptr[0][15:8] = i_wdata;
              `CMA_OFF_PTR1_LO: n.ptr[1][7:0] = i_wdata;
              `CMA_OFF_PTR1_HI: n.ptr[1][15:8] = i_wdata;
              `CMA_OFF_BANK: n.bank_sel = i_wdata[4:0];
              `CMA_OFF_W: n.w = i_wdata;
              `CMA_OFF_PC_HIGH: n.pc_hi = {1'b0, i_wdata[6:0]};
              `CMA_OFF_IRQ_CTL: n.irq_ctl = i_wdata;
              default: ;
            endcase
          end else if (gi[16]) begin
            n.ram[gi[15:0]] = i_wdata;
          end else if (a[6:0] >= `CMA_COMMON_START) begin
            n.common[a[3:0]] = i_wdata;
          end
        end
        if (push) begin
          if (r.depth == `CMA_STACK_FULL) begin
            n.ovf = 1'b1;
            srst = i_stack_reset_en;
          end else begin
            n.stack[r.depth[3:0]] = n.pc;
            n.depth = r.depth + 5'h01;
          end
          if (i_op == CMA_OP_IRQ) begin
            n.pc = `CMA_IRQ_VEC;
            n.sh_w = r.w;
            n.sh_flags = r.status[2:0];
            n.sh_bank = r.bank_sel;
            n.sh_pc_hi = r.pc_hi;
            n.sh_ptr = r.ptr;
            n.irq_ctl[`CMA_GIE_BIT] = 1'b0;
          end else begin
            n.pc = i_target & PM_MASK;
          end
        end
        if (pop) begin
          if (r.depth == 5'h00) begin
            n.unf = 1'b1;
            srst = i_stack_reset_en;
          end else begin
            n.depth = r.depth - 5'h01;
            n.pc = r.stack[4'(r.depth - 5'h01)];
          end
          if (i_op == CMA_OP_RETFIE) begin
            n.w = r.sh_w;
            n.status[2:0] = r.sh_flags;
            n.bank_sel = r.sh_bank;
            n.pc_hi = r.sh_pc_hi;
            n.ptr = r.sh_ptr;
            n.irq_ctl[`CMA_GIE_BIT] = 1'b1;
          end
        end
      end
      // Watchdog and sleep bits follow their events, never a write.
      if (i_wdt_clear) begin
        n.status[`CMA_ST_WDT] = 1'b1;
        n.status[`CMA_ST_SLEEP] = 1'b1;
      end
      if (i_sleep_enter) begin
        n.status[`CMA_ST_WDT] = 1'b1;
        n.status[`CMA_ST_SLEEP] = 1'b0;
      end
      if (i_wdt_expire) begin
        n.status[`CMA_ST_WDT] = 1'b0;
      end
      if (i_flags_we) begin
        n.status[2:0] = i_flags;
      end
      if (srst) begin
        // The flags must survive so software can see the cause.
        n = RST_STATE;
        n.ovf = r.ovf | (push & ~pop);
        n.unf = r.unf | pop;
        n.soft_rst = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  assign o_pc = r.pc;
  assign o_busy = r.phase[1];
  assign o_rdata = r.rdata;
  assign o_rvalid = r.rvalid;
  assign o_pm_rd = r.pm_rd;
  assign o_pm_addr = r.pm_addr;
  assign o_pm_hef = r.hef;
  assign o_w = r.w;
  assign o_status = {3'h0, r.status};
  assign o_bank = r.bank_sel;
  assign o_irq_control = r.irq_ctl;
  assign o_depth = r.depth;
  assign o_stack_over_flag = r.ovf;
  assign o_stack_under_flag = r.unf;
  assign o_soft_reset = r.soft_rst;

  logic acc;
  assign acc = i_ce && i_req && (r.phase == CMA_IDLE);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_pm_req;
    acc && (i_op == CMA_OP_IND_READ || i_op == CMA_OP_IND_TO_W)
      && r.ptr[i_sel][`CMA_PM_SEL_BIT];
  endsequence

  sequence s_pm_wait;
    o_busy && o_pm_rd;
  endsequence

  sequence s_pm_done;
    o_rvalid && !o_busy && o_rdata == $past(i_pm_data[7:0]);
  endsequence

  a_pc_reset: assert property (disable iff (1'b0)
    !i_nrst |=> o_pc == `CMA_RESET_VEC && o_status == 8'h18)
    else $error("pc or status not at reset value");
  a_pm_extra: assert property (
    (s_pm_req ##1 i_ce) |-> s_pm_wait ##1 s_pm_done)
    else $error("program read did not take one extra cycle");
  a_ind_w_low: assert property (
    (s_pm_req ##0 i_op == CMA_OP_IND_TO_W ##1 i_ce)
      |=> o_w == $past(i_pm_data[7:0]))
    else $error("W not loaded with low byte of program word");
  a_irq_vector: assert property (
    acc && i_op == CMA_OP_IRQ && o_depth < `CMA_STACK_FULL
      |=> o_pc == `CMA_IRQ_VEC && o_depth == $past(o_depth) + 5'h01
        && !o_irq_control[`CMA_GIE_BIT])
    else $error("interrupt did not vector to 0004h");
  a_stack_over: assert property (
    acc && i_op == CMA_OP_CALL && o_depth == `CMA_STACK_FULL
      |=> o_stack_over_flag && o_soft_reset == $past(i_stack_reset_en))
    else $error("stack overflow not flagged");
  a_stack_under: assert property (
    acc && i_op == CMA_OP_RETURN && o_depth == 5'h00
      |=> o_stack_under_flag && o_soft_reset == $past(i_stack_reset_en))
    else $error("stack underflow not flagged");
  a_depth_limit: assert property (
    o_depth <= `CMA_STACK_FULL)
    else $error("stack depth beyond sixteen");
  a_pc_wrap: assert property (
    (o_pc & ~PM_MASK) == 15'h0000 && (o_pm_addr & ~PM_MASK) == 15'h0000)
    else $error("program address outside implemented memory");
  a_status_lock: assert property (
    acc && i_op == CMA_OP_WRITE && i_addr == `CMA_OFF_STATUS && i_flags_we
      |=> o_status[2:0] == $past(i_flags))
    else $error("status write not blocked by flag update");
  a_wdt_bits_held: assert property (
    i_ce && !i_wdt_expire && !i_sleep_enter && !i_wdt_clear
      |=> o_soft_reset || o_status[4:3] == $past(o_status[4:3]))
    else $error("timeout or power-down bit changed without event");
  a_bank_sel: assert property (
    acc && i_op == CMA_OP_WRITE && i_addr == `CMA_OFF_BANK
      |=> o_bank == $past(i_wdata[4:0]))
    else $error("bank select not updated");
  a_unimpl_zero: assert property (
    acc && i_op == CMA_OP_READ && i_addr >= `CMA_CORE_END
      && i_addr < `CMA_RAM_START
      |=> o_rvalid && o_rdata == 8'h00)
    else $error("unimplemented location did not read zero");

endmodule // cma_memory_addressing

// >>> logic/cma_pkg.sv
package cma_pkg;
  typedef enum logic [3:0] {
    CMA_OP_NOP = 4'h0,
    CMA_OP_READ = 4'h1,
    CMA_OP_WRITE = 4'h2,
    CMA_OP_IND_READ = 4'h3,
    CMA_OP_IND_WRITE = 4'h4,
    CMA_OP_IND_TO_W = 4'h5,
    CMA_OP_CALL = 4'h6,
    CMA_OP_RETURN = 4'h7,
    CMA_OP_GOTO = 4'h8,
    CMA_OP_IRQ = 4'h9,
    CMA_OP_RETFIE = 4'hA
  } cma_op_t;

  typedef enum logic [1:0] {
    CMA_IDLE = 2'b01,
    CMA_PM_WAIT = 2'b10
  } cma_phase_t;
endpackage
